// >>> sab_pkg.sv
// Purpose: shared constants for the converter control and bus interface
// Assumes: 40 MHz ref_clk_i, synchronous active-high reset
// Notes:
// Behaviour
// - data lines driven only while select and read strobe are both low
// - 12-bit result plus status bit delivered as two bytes
// - byte select low gives result bits 7..0, lsb on line 0
// - byte select high gives status, three zeros, result bits 11..8
// - status bit high while converting, low when finished
// - busy output low for the whole conversion, high otherwise
// - write strobe with select low starts a conversion
// - reads during conversion return the partial approximation register
// - a start during a conversion abandons it and restarts
// - autozero while idle, at least 10 us before every internal-clock conversion
// - internal clock: autozero extended after strobe, then 12 decision pulses
// - external clock: msb decided on second falling clock edge after strobe
// - at 140 kHz a full conversion with autozero takes about 96 us
// - natural binary code, 4096 equal steps
// - byte select change during a read switches the driven byte
package sab_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned AZ_TIME_NS    = 10_000;
    localparam int unsigned CONV_CLK_HZ   = 140_000;
    // least time: round up
    localparam int unsigned AZ_CYC_INT    = (AZ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // converter clock period: longest, round down
    localparam int unsigned CONV_CYC_INT  = CLK_HZ / CONV_CLK_HZ;
    localparam logic [11:0] AZ_CYC        = AZ_CYC_INT[11:0];
    localparam logic [11:0] CONV_CYC      = CONV_CYC_INT[11:0];

    localparam int unsigned RES_BITS      = 12;
    localparam logic [11:0] SAR_FIRST     = 12'h0800;
    localparam logic [3:0]  MSB_IDX       = 4'hb;
    localparam logic [1:0]  EXT_EDGE_MSB  = 2'h2;

    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;
    localparam int unsigned CTRL_EXT_BIT  = 0;
    localparam int unsigned STAT_BUSY_BIT = 31;
    localparam logic        CTRL_RESET    = 1'b0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b11
    } sab_state_t;
endpackage

// >>> sab_tick_gen.sv
// Purpose: autozero timing and decision strobes from internal or external clock
// Assumes: conv_clk_i is synchronous to ref_clk_i
// Notes: run_i low holds the counters cleared and both outputs low
`timescale 1ns/10ps
module sab_tick_gen
    import sab_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic ext_mode_i,
    input  wire logic run_i,
    input  wire logic conv_clk_i,
    output logic      az_o,
    output logic      tick_o
);
    logic [11:0] cnt_q;
    logic        az_q;
    logic        clk_prev_q;
    logic [1:0]  fall_cnt_q;

    wire fall     = clk_prev_q && !conv_clk_i;
    wire az_end   = az_q && (cnt_q == AZ_CYC - 12'h001);
    wire per_end  = !az_q && (cnt_q == CONV_CYC - 12'h001);
    wire int_tick = !ext_mode_i && per_end;
    // first falling edge only arms, second and later decide
    wire ext_tick = ext_mode_i && fall && (fall_cnt_q != 2'h0);

    assign az_o   = run_i && az_q && !ext_mode_i;
    assign tick_o = run_i && (int_tick || ext_tick);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= conv_clk_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !run_i) begin
            cnt_q      <= 12'h000;
            az_q       <= 1'b1;
            fall_cnt_q <= 2'h0;
        end else begin
            // internal mode extends autozero itself after the strobe
            cnt_q <= (az_end || per_end || ext_mode_i) ? 12'h000 : cnt_q + 12'h001;
            if (az_end || ext_mode_i) begin
                az_q <= 1'b0;
            end
            if (fall && fall_cnt_q != EXT_EDGE_MSB) begin
                fall_cnt_q <= fall_cnt_q + 2'h1;
            end
        end
    end

    chk_az_min_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (run_i && !ext_mode_i && $rose(run_i)) |-> !tick_o [*8])
        else $error("decision strobe too early after autozero start");
    chk_ext_second_edge: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (run_i && ext_mode_i && tick_o) |-> fall && fall_cnt_q != 2'h0)
        else $error("external decision not on second or later falling edge");
endmodule

// >>> sab_sar.sv
// Purpose: successive approximation register, msb first, natural binary
// Assumes: comparator_i high means input at or above the trial code
// Notes: done_o pulses once after the twelfth decision
`timescale 1ns/10ps
module sab_sar
    import sab_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clear_i,
    input  wire logic        tick_i,
    input  wire logic        comparator_i,
    output logic      [11:0] sar_o,
    output logic             done_o
);
    logic [11:0] sar_q;
    logic [3:0]  idx_q;
    logic        active_q;
    logic        done_q;
    logic [3:0]  dec_cnt_q;

    wire         step    = tick_i && active_q;
    wire         last    = (idx_q == 4'h0);
    wire  [11:0] bit_sel = 12'h001 << idx_q;
    wire  [11:0] nxt_sel = last ? 12'h000 : (bit_sel >> 1);
    // keep or drop the trial bit, then place the next trial bit
    wire  [11:0] kept    = comparator_i ? sar_q : (sar_q & ~bit_sel);

    assign sar_o  = sar_q;
    assign done_o = done_q;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sar_q     <= 12'h000;
            idx_q     <= MSB_IDX;
            active_q  <= 1'b0;
            done_q    <= 1'b0;
            dec_cnt_q <= 4'h0;
        end else if (clear_i) begin
            sar_q     <= SAR_FIRST;
            idx_q     <= MSB_IDX;
            active_q  <= 1'b1;
            done_q    <= 1'b0;
            dec_cnt_q <= 4'h0;
        end else begin
            done_q <= step && last;
            if (step) begin
                sar_q     <= kept | nxt_sel;
                idx_q     <= last ? MSB_IDX : idx_q - 4'h1;
                active_q  <= !last;
                dec_cnt_q <= dec_cnt_q + 4'h1;
            end
        end
    end

    chk_twelve_steps: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(done_q) |-> dec_cnt_q == 4'hc)
        else $error("conversion ended without twelve decisions");
endmodule

// >>> sab_top.sv
// Purpose: converter control, host byte bus and register slave
// Assumes: host pins synchronous to ref_clk_i; data pins resolved outside
// Notes: pin outputs lag their inputs by one clock
`timescale 1ns/10ps
module sab_top
    import sab_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        byte_select_i,
    input  wire logic        conv_clk_i,
    input  wire logic        comparator_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_o,
    output logic             busy_n_o,
    output logic             autozero_o,
    output logic      [11:0] trial_code_o,
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic      [1:0]  s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic      [31:0] s_axi_rdata_o,
    output logic      [1:0]  s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i
);
    sab_state_t  state_q;
    sab_state_t  state_d;
    logic        ext_mode_q;
    logic [7:0]  data_q;
    logic        data_oe_q;
    logic        busy_n_q;
    logic        az_q;
    logic        wr_rdy_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        ar_rdy_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [11:0] sar;
    logic        sar_done;
    logic        tick;
    logic        tick_az;

    // select high masks both strobes
    wire start   = !cs_n_i && !wr_n_i;
    wire reading = !cs_n_i && !rd_n_i;
    wire run     = (state_q == ST_RUN);
    wire busy    = (state_q != ST_IDLE);

    function automatic logic [7:0] bus_byte(input logic hi, input logic bsy,
                                           input logic [11:0] code);
        bus_byte = hi ? {bsy, 3'b000, code[11:8]} : code[7:0];
    endfunction

    // the live register is shown, so mid-conversion reads see partial codes
    wire [7:0] byte_d = bus_byte(byte_select_i, busy, sar);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!start) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (start) begin
                    state_d = ST_HOLD;
                end else if (sar_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire busy_n_d = (state_d == ST_IDLE);
    // autozero while idle, while the strobe is held and, in internal mode, until the timer ends it
    wire az_d     = (state_d != ST_RUN) || (tick_az && !sar_done);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q    <= ST_IDLE;
            data_q     <= 8'h00;
            data_oe_q  <= 1'b0;
            busy_n_q   <= 1'b1;
            az_q       <= 1'b1;
        end else begin
            state_q    <= state_d;
            data_q     <= byte_d;
            data_oe_q  <= reading;
            busy_n_q   <= busy_n_d;
            az_q       <= az_d;
        end
    end

    sab_tick_gen u_tick (
        .ref_clk_i  (ref_clk_i),
        .reset_i    (reset_i),
        .ext_mode_i (ext_mode_q),
        .run_i      (run),
        .conv_clk_i (conv_clk_i),
        .az_o       (tick_az),
        .tick_o     (tick)
    );

    sab_sar u_sar (
        .ref_clk_i    (ref_clk_i),
        .reset_i      (reset_i),
        .clear_i      (start),
        .tick_i       (tick),
        .comparator_i (comparator_i),
        .sar_o        (sar),
        .done_o       (sar_done)
    );

    // register slave: write address and data are taken together
    wire       wr_take  = wr_rdy_q && s_axi_awvalid_i && s_axi_wvalid_i;
    wire       wr_ctrl  = (s_axi_awaddr_i == ADDR_CTRL);
    wire       wr_stat  = (s_axi_awaddr_i == ADDR_STATUS);
    wire       rd_take  = ar_rdy_q && s_axi_arvalid_i;
    wire       rd_ctrl  = (s_axi_araddr_i == ADDR_CTRL);
    wire       rd_stat  = (s_axi_araddr_i == ADDR_STATUS);
    wire [31:0] ctrl_rd = {31'h0000_0000, ext_mode_q};
    wire [31:0] stat_rd = {busy, 19'h0_0000, sar};
    wire [31:0] rd_word = rd_ctrl ? ctrl_rd : (rd_stat ? stat_rd : 32'h0000_0000);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ext_mode_q <= CTRL_RESET;
            wr_rdy_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
        end else begin
            wr_rdy_q <= !wr_rdy_q && !bvalid_q && s_axi_awvalid_i && s_axi_wvalid_i;
            if (wr_take) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && s_axi_wstrb_i[0]) begin
                    ext_mode_q <= s_axi_wdata_i[CTRL_EXT_BIT];
                end
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else begin
            ar_rdy_q <= !ar_rdy_q && !rvalid_q && s_axi_arvalid_i;
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign data_o          = data_q;
    assign data_oe_o       = data_oe_q;
    assign busy_n_o        = busy_n_q;
    assign autozero_o      = az_q;
    assign trial_code_o    = sar;
    assign s_axi_awready_o = wr_rdy_q;
    assign s_axi_wready_o  = wr_rdy_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign s_axi_arready_o = ar_rdy_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // pin side
    chk_bus_drive_gate: assert property (
        data_oe_o == $past(reading))
        else $error("data enable does not follow select and read");

    chk_write_no_drive: assert property (
        (!cs_n_i && !wr_n_i && rd_n_i) |=> !data_oe_o)
        else $error("data driven during a start strobe");

    chk_low_byte: assert property (
        (reading && !byte_select_i) |=> data_o == $past(sar[7:0]))
        else $error("low byte content wrong");

    chk_high_byte: assert property (
        (reading && byte_select_i) |=> data_o == {$past(busy), 3'b000, $past(sar[11:8])})
        else $error("high byte content wrong");

    chk_high_zeros: assert property (
        (reading && byte_select_i) |=> data_o[6:4] == 3'b000)
        else $error("unused high byte lines not low");

    chk_status_busy: assert property (
        (reading && byte_select_i && busy) |=> data_o[7])
        else $error("status bit low during conversion");

    chk_status_done: assert property (
        (reading && byte_select_i && !busy) |=> !data_o[7])
        else $error("status bit high while idle");

    chk_busy_pin: assert property (
        busy_n_o == (state_q == ST_IDLE))
        else $error("busy pin disagrees with conversion state");

    chk_busy_fall: assert property (
        $fell(busy_n_o) |-> $past(start))
        else $error("busy asserted without a start strobe");

    chk_busy_rise: assert property (
        $rose(busy_n_o) |-> $past(sar_done))
        else $error("busy released before the last decision");

    chk_start_conv: assert property (
        start |=> (state_q == ST_HOLD) && !busy_n_o)
        else $error("start strobe did not begin a conversion");

    chk_restart_clear: assert property (
        (run && start) |=> sar == SAR_FIRST && state_q == ST_HOLD)
        else $error("restart did not abandon the conversion");

    chk_unselected_idle: assert property (
        (cs_n_i && state_q == ST_IDLE) |=> state_q == ST_IDLE && !data_oe_o)
        else $error("strobes acted without select");

    chk_done_release: assert property (
        (run && sar_done && !start) |=> busy_n_o ##1 busy_n_o || state_q != ST_IDLE)
        else $error("busy not released at conversion end");

    chk_idle_autozero: assert property (
        busy_n_o |-> autozero_o)
        else $error("autozero off between conversions");

    chk_strobe_autozero: assert property (
        (state_q == ST_HOLD) |-> autozero_o)
        else $error("autozero off while the strobe is held");

    // external mode: the held strobe was the whole autozero
    chk_ext_az_end: assert property (
        (ext_mode_q && run && state_d == ST_RUN) |=> !autozero_o)
        else $error("autozero extended in external clock mode");

    chk_result_held: assert property (
        (state_q == ST_IDLE && !start) |=> $stable(sar))
        else $error("result changed between conversions");

    chk_first_trial: assert property (
        $rose(run) |-> sar == SAR_FIRST)
        else $error("first trial code is not the msb");

    chk_tick_spacing: assert property (
        (run && !ext_mode_q && tick) |=> !tick [*8])
        else $error("internal decisions too close together");

    // register side: ready is a one-cycle pulse, so a held request is not taken twice
    chk_aw_pulse: assert property (
        s_axi_awready_o |=> !s_axi_awready_o)
        else $error("write ready held for two cycles");

    chk_ar_pulse: assert property (
        s_axi_arready_o |=> !s_axi_arready_o)
        else $error("read ready held for two cycles");

    chk_wr_answer: assert property (
        (s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i) |=> s_axi_bvalid_o)
        else $error("write taken without a response");

    chk_rd_answer: assert property (
        (s_axi_arready_o && s_axi_arvalid_i) |=> s_axi_rvalid_o)
        else $error("read taken without a response");

    chk_bvalid_hold: assert property (
        (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o)
        else $error("write response dropped before bready");

    chk_rdata_hold: assert property (
        (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read response changed before rready");

    chk_no_accept_busy: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("new write accepted while a response is pending");

    chk_ctrl_write_only: assert property (
        !(s_axi_awready_o && s_axi_awvalid_i) |=> $stable(ext_mode_q))
        else $error("clock mode changed without a write");
endmodule

// >>> sab_host_bfm.sv
// Purpose: host bus model driving select, strobes and byte select
// Assumes: every pin changes just after a ref_clk_i edge
// Notes: undriven data lines read as z, so a floating bus never matches
`timescale 1ns/10ps
module sab_host_bfm (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] data_i,
    input  wire logic       data_oe_i,
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            byte_select_o
);
    wire [7:0] bus = data_oe_i ? data_i : 8'hzz;

    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        byte_select_o = 1'b0;
    end

    // select follows sel_n over the whole strobe, stretched or not
    task start_conv(input int hold, input logic sel_n);
        @(posedge ref_clk_i);
        cs_n_o <= sel_n;
        wr_n_o <= 1'b0;
        repeat (hold) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        wr_n_o <= 1'b1;
    endtask

    task open_read(input logic bsel, input logic sel_n);
        @(posedge ref_clk_i);
        cs_n_o <= sel_n;
        rd_n_o <= 1'b0;
        byte_select_o <= bsel;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    task set_sel(input logic bsel);
        @(posedge ref_clk_i);
        byte_select_o <= bsel;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    task close_read;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    // one access per byte, any order
    task read_byte(input logic bsel, output logic [7:0] d);
        open_read(bsel, 1'b0);
        d = bus;
        close_read;
    endtask
endmodule

// >>> sab_top_tb.sv
// Purpose: self-checking bench for converter control and host bus
// Assumes: ideal comparator fed from trial_code_o one clock late
// Notes: internal conversions except the first of t_restart run full length, about 3.8k clocks each
`timescale 1ns/10ps
module sab_top_tb
    import sab_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        conv_clk_i = 1'b0;
    logic        comparator_i = 1'b0;
    logic        ext_run = 1'b0;
    logic [11:0] analog_input = 12'h000;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [4:0]  cdiv = 5'h00;
    logic [7:0]  lo;
    logic [7:0]  hi;
    wire  [31:0] rdata;
    wire  [11:0] trial;
    wire  [7:0]  data;
    wire  [1:0]  bresp;
    wire  [1:0]  rresp;
    wire         oe, busy_n, az, awready, wready, bvalid, arready, rvalid, cs_n, rd_n, wr_n, bs;
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t0;
    int          n;

    always #12.5 ref_clk_i = ~ref_clk_i;

    // external clock 20 clocks, 50/50, still outside frames
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        comparator_i <= (analog_input >= trial);
        cdiv <= (ext_run && cdiv != 5'h13) ? cdiv + 5'h01 : 5'h00;
        conv_clk_i <= ext_run && cdiv < 5'h0a;
    end

    sab_top dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .byte_select_i(bs), .conv_clk_i(conv_clk_i), .comparator_i(comparator_i),
        .data_o(data), .data_oe_o(oe), .busy_n_o(busy_n), .autozero_o(az), .trial_code_o(trial),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    sab_host_bfm host_u (.ref_clk_i(ref_clk_i), .data_i(data), .data_oe_i(oe), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .byte_select_o(bs));

    task check(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t ns %s", $time, msg);
        end
    endtask

    task complete_run;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                input logic [1:0] er);
        bit ad;
        bit wd;
        ad = 0;
        wd = 0;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge ref_clk_i);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge ref_clk_i);
        check(bvalid === 1'b1 && bresp === er, "write response");
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (arready !== 1'b1) @(posedge ref_clk_i);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk_i);
        check(rvalid === 1'b1 && rresp === er && (er !== RESP_OKAY || rdata === d), "read data");
        rready <= 1'b0;
    endtask

    // result is read once busy has returned high, or after 5000 clocks
    task finish(input int lo_b, input int hi_b);
        for (n = cyc - t0; n < 5000 && busy_n !== 1'b1; n = cyc - t0) @(posedge ref_clk_i);
        check(n >= lo_b && n <= hi_b, "busy length");
        host_u.read_byte(1'b0, lo);
        host_u.read_byte(1'b1, hi);
        check(lo === analog_input[7:0] && hi === {4'h0, analog_input[11:8]}, "result");
        axi_rd(ADDR_STATUS, {20'h0_0000, analog_input}, RESP_OKAY);
    endtask

    task t_idle;
        check(busy_n === 1'b1 && az === 1'b1 && oe === 1'b0, "idle pins");
        host_u.start_conv(6, 1'b1);
        repeat (3) @(posedge ref_clk_i);
        check(busy_n === 1'b1, "start while deselected");
        host_u.open_read(1'b0, 1'b1);
        check(oe === 1'b0, "drive while deselected");
        host_u.close_read;
        axi_rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_rd(4'hc, 32'h0000_0000, RESP_SLVERR);
        $display("test idle done");
    endtask

    task t_conv(input logic [11:0] v);
        logic [11:0] ex;
        ex = (v & 12'hf80) | 12'h040;
        analog_input <= v;
        host_u.start_conv(10, 1'b0);
        t0 = cyc;
        check(busy_n === 1'b0, "busy during strobe");
        repeat (300) @(posedge ref_clk_i);
        check(az === 1'b1, "autozero held");
        repeat (120) @(posedge ref_clk_i);
        check(az === 1'b0, "autozero ended");
        repeat (1540) @(posedge ref_clk_i);
        host_u.read_byte(1'b1, hi);
        host_u.read_byte(1'b0, lo);
        check(hi === {4'h8, ex[11:8]}, "mid high byte");
        check(lo === ex[7:0], "mid low byte");
        // 4000 clocks is 100 us
        finish(AZ_CYC_INT + 12 * CONV_CYC_INT, 4000);
        $display("test conversion %h done", v);
    endtask

    task t_switch;
        host_u.open_read(1'b0, 1'b0);
        check(host_u.bus === analog_input[7:0], "low byte driven");
        host_u.set_sel(1'b1);
        check(host_u.bus === {4'h0, analog_input[11:8]}, "byte switch");
        host_u.close_read;
        check(oe === 1'b0, "bus released");
        $display("test byte switch done");
    endtask

    task t_restart;
        analog_input <= 12'h5a3;
        host_u.start_conv(10, 1'b0);
        repeat (1000) @(posedge ref_clk_i);
        host_u.start_conv(10, 1'b0);
        t0 = cyc;
        check(trial === SAR_FIRST, "restart reload");
        finish(AZ_CYC_INT + 12 * CONV_CYC_INT, 4000);
        $display("test restart done");
    endtask

    task t_ext;
        axi_wr(ADDR_CTRL, 32'h0000_0001, 4'h0, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'h0000_0001, 4'hf, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        analog_input <= 12'h3c6;
        host_u.start_conv(AZ_CYC_INT + 20, 1'b0);
        ext_run <= 1'b1;
        t0 = cyc;
        check(az === 1'b1 && busy_n === 1'b0, "strobe autozero");
        @(negedge conv_clk_i);
        repeat (4) @(posedge ref_clk_i);
        check(trial === SAR_FIRST, "early decision");
        @(negedge conv_clk_i);
        repeat (4) @(posedge ref_clk_i);
        check(trial[11:10] === 2'b01, "msb decision");
        finish(251, 270);
        ext_run <= 1'b0;
        axi_wr(ADDR_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_wr(4'hc, 32'h0000_0001, 4'hf, RESP_SLVERR);
        axi_wr(ADDR_CTRL, 32'h0000_0000, 4'hf, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        $display("test external clock done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_idle;
        t_conv(12'hfff);
        t_conv(12'h000);
        t_conv(12'ha5c);
        t_switch;
        t_restart;
        t_ext;
        complete_run;
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        fails++;
        complete_run;
    end
endmodule
